/* hdl/sdr_pkg.sv */
// package: event codes, message layout and carrier types of the reporter
package sdr_pkg;
  // ----------------------------------------------------------------
  // event codes; all but the ready code are carried in byte 0
  // ----------------------------------------------------------------
  localparam logic [7:0] SDR_CODE_NEW_ADDR  = 8'h3C;
  localparam logic [7:0] SDR_CODE_READY     = 8'h3D;
  localparam logic [7:0] SDR_CODE_DATA_EXCH = 8'h3E;
  localparam logic [7:0] SDR_CODE_IO_FAIL   = 8'h2B;
  localparam logic [7:0] SDR_CODE_ACK_DELAY = 8'h2B;
  // ----------------------------------------------------------------
  // message layout, reset address and restart length
  // ----------------------------------------------------------------
  localparam logic [7:0] SDR_SLOT_NONE  = 8'h00;
  localparam logic [5:0] SDR_SLOT_MAX   = 6'h20;
  localparam logic [1:0] SDR_MSG_LEN    = 2'h2;
  localparam logic [1:0] SDR_MSG_LEN1   = 2'h1;
  localparam logic [6:0] SDR_ADDR_RESET = 7'h7E;
  localparam logic [7:0] SDR_RST_CYC    = 8'h10;

  // event request: code plus optional slot number
  typedef struct packed {
    logic [7:0] code;
    logic [5:0] slot;
  } sdr_evt_s;

  // one byte on the diagnostic output
  typedef struct packed {
    logic [7:0] data;
    logic       first;
    logic       last;
  } sdr_byte_s;
endpackage : sdr_pkg

/* hdl/sdr_reporter.sv */
// module: diagnostic message framer of the slave reporter
`timescale 1ns/1ns
module sdr_reporter
  import sdr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        setAddrReq,
  input  wire logic [6:0]  setAddrValue,
  input  wire logic        slaveReady,
  input  wire logic        dataExchange,
  input  wire logic        ioReadFail,
  input  wire logic        ioWriteFail,
  input  wire logic [5:0]  ioSlot,
  input  wire logic        ackDelay,
  input  wire logic [5:0]  ackSlot,
  input  wire logic        txReady,
  output logic             txValid,
  output sdr_byte_s        txByte,
  output logic             restartReq,
  output logic [6:0]       stationAddress,
  output logic [7:0]       readyCode,
  output logic             busy
);
  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SDR_IDLE  = 2'b00,
    SDR_BYTE0 = 2'b01,
    SDR_BYTE1 = 2'b11,
    SDR_RESET = 2'b10
  } sdr_state_e;

  sdr_state_e state_r, state_nxt;
  sdr_evt_s   evt_r, evt_nxt;
  logic       oneByte_r, oneByte_nxt;
  logic       restart_r, restart_nxt;
  logic [7:0] rstCnt_r, rstCnt_nxt;
  logic [6:0] addr_r, addr_nxt;
  logic [6:0] pendAddr_r, pendAddr_nxt;
  logic       dxPrev_r, dxPrev_nxt;
  logic       txValid_r, txValid_nxt;
  sdr_byte_s  txByte_r, txByte_nxt;
  logic [7:0] slotByte;
  logic       dxRise;

  sdr_slot_encode u_slot (
    .slotIn   (evt_r.slot),
    .slotByte (slotByte)
  );

  assign dxRise = dataExchange && !dxPrev_r;

  // ----------------------------------------------------------------
  // next state: event priority address > io fail > ack delay > dx
  // ----------------------------------------------------------------
  // events arriving while a message is in flight are not queued; the
  // sources hold them as levels or repeat them, so nothing is buffered
  always_comb begin
    state_nxt    = state_r;
    evt_nxt      = evt_r;
    oneByte_nxt  = oneByte_r;
    restart_nxt  = 1'b0;
    rstCnt_nxt   = rstCnt_r;
    addr_nxt     = addr_r;
    pendAddr_nxt = pendAddr_r;
    dxPrev_nxt   = dataExchange;
    txValid_nxt  = txValid_r;
    txByte_nxt   = txByte_r;
    unique case (state_r)
      SDR_IDLE: begin
        if (setAddrReq) begin
          evt_nxt      = '{code: SDR_CODE_NEW_ADDR, slot: 6'h00};
          oneByte_nxt  = 1'b1;
          pendAddr_nxt = setAddrValue;
          state_nxt    = SDR_BYTE0;
        end else if (ioReadFail || ioWriteFail) begin
          evt_nxt     = '{code: SDR_CODE_IO_FAIL, slot: ioSlot};
          oneByte_nxt = 1'b0;
          state_nxt   = SDR_BYTE0;
        end else if (ackDelay) begin
          evt_nxt     = '{code: SDR_CODE_ACK_DELAY, slot: ackSlot};
          oneByte_nxt = 1'b0;
          state_nxt   = SDR_BYTE0;
        end else if (dxRise) begin
          evt_nxt     = '{code: SDR_CODE_DATA_EXCH, slot: 6'h00};
          oneByte_nxt = 1'b1;
          state_nxt   = SDR_BYTE0;
        end
        if (state_nxt == SDR_BYTE0) begin
          txValid_nxt = 1'b1;
          txByte_nxt  = '{data: evt_nxt.code, first: 1'b1,
                          last: oneByte_nxt};
        end
      end
      SDR_BYTE0: begin
        if (txReady) begin
          if (oneByte_r) begin
            txValid_nxt = 1'b0;
            if (evt_r.code == SDR_CODE_NEW_ADDR) begin
              state_nxt  = SDR_RESET;
              rstCnt_nxt = SDR_RST_CYC;
            end else begin
              state_nxt = SDR_IDLE;
            end
          end else begin
            txByte_nxt = '{data: slotByte, first: 1'b0, last: 1'b1};
            state_nxt  = SDR_BYTE1;
          end
        end
      end
      SDR_BYTE1: begin
        if (txReady) begin
          txValid_nxt = 1'b0;
          state_nxt   = SDR_IDLE;
        end
      end
      SDR_RESET: begin
        // restart pulse held; address swaps only once the restart ends
        restart_nxt = 1'b1;
        rstCnt_nxt  = rstCnt_r - 8'h01;
        if (rstCnt_r == 8'h01) begin
          addr_nxt    = pendAddr_r;
          restart_nxt = 1'b0;
          state_nxt   = SDR_IDLE;
        end
      end
      default: state_nxt = SDR_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r    <= SDR_IDLE;
      evt_r      <= '0;
      oneByte_r  <= 1'b0;
      restart_r  <= 1'b0;
      rstCnt_r   <= 8'h00;
      addr_r     <= SDR_ADDR_RESET;
      pendAddr_r <= SDR_ADDR_RESET;
      dxPrev_r   <= 1'b0;
      txValid_r  <= 1'b0;
      txByte_r   <= '0;
    end else begin
      state_r    <= state_nxt;
      evt_r      <= evt_nxt;
      oneByte_r  <= oneByte_nxt;
      restart_r  <= restart_nxt;
      rstCnt_r   <= rstCnt_nxt;
      addr_r     <= addr_nxt;
      pendAddr_r <= pendAddr_nxt;
      dxPrev_r   <= dxPrev_nxt;
      txValid_r  <= txValid_nxt;
      txByte_r   <= txByte_nxt;
    end
  end

  // ready code is internal status only and never enters the tx path
  logic [7:0] readyCode_r;
  logic       busy_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      readyCode_r <= 8'h00;
      busy_r      <= 1'b0;
    end else begin
      readyCode_r <= slaveReady ? SDR_CODE_READY : 8'h00;
      busy_r      <= (state_nxt != SDR_IDLE);
    end
  end

  assign txValid        = txValid_r;
  assign txByte         = txByte_r;
  assign restartReq     = restart_r;
  assign stationAddress = addr_r;
  assign readyCode      = readyCode_r;
  assign busy           = busy_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_addrMsg;
    txValid && txByte.data == SDR_CODE_NEW_ADDR && txByte.first;
  endsequence
  // the address message is only done once the consumer has taken it
  sequence s_addrTaken;
    txValid && txByte.data == SDR_CODE_NEW_ADDR && txByte.first && txReady;
  endsequence
  sequence s_restart;
    !restartReq ##[1:300] restartReq;
  endsequence

  property p_slot_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_r == SDR_BYTE1 && (evt_r.slot == 6'h00))
      |-> txByte.data == SDR_SLOT_NONE;
  endproperty
  a_slot_zero: assert property (p_slot_zero)
    else $error("unknown slot not sent as zero");

  property p_slot_range;
    @(posedge sys_clk) disable iff (!rst_n)
      (txValid && !txByte.first) |-> txByte.data <= 8'h20;
  endproperty
  a_slot_range: assert property (p_slot_range)
    else $error("slot byte above 32");

  property p_msg_then_restart;
    @(posedge sys_clk) disable iff (!rst_n)
      s_addrTaken |-> s_restart;
  endproperty
  a_msg_then_restart: assert property (p_msg_then_restart)
    else $error("no restart after address message");

  property p_addr_after_restart;
    @(posedge sys_clk) disable iff (!rst_n)
      $fell(restartReq) |-> stationAddress == pendAddr_r;
  endproperty
  a_addr_after_restart: assert property (p_addr_after_restart)
    else $error("station address not updated");

  property p_addr_code;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_r == SDR_IDLE && setAddrReq) |=> s_addrMsg;
  endproperty
  a_addr_code: assert property (p_addr_code)
    else $error("address message code wrong");

  property p_ready_internal;
    @(posedge sys_clk) disable iff (!rst_n)
      txValid |-> txByte.data != SDR_CODE_READY;
  endproperty
  a_ready_internal: assert property (p_ready_internal)
    else $error("ready code transmitted");

  property p_dx_code;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_r == SDR_IDLE && dxRise && !setAddrReq && !ioReadFail
       && !ioWriteFail && !ackDelay)
      |=> txValid && txByte.data == SDR_CODE_DATA_EXCH && txByte.last;
  endproperty
  a_dx_code: assert property (p_dx_code)
    else $error("data exchange not reported");

  property p_two_byte;
    @(posedge sys_clk) disable iff (!rst_n)
      (txValid && txByte.first && txByte.data == SDR_CODE_ACK_DELAY
       && txReady) |=> txValid && txByte.last && !txByte.first;
  endproperty
  a_two_byte: assert property (p_two_byte)
    else $error("delayed ack not two bytes");

  property p_io_fail;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_r == SDR_IDLE && !setAddrReq && (ioReadFail || ioWriteFail))
      |=> txValid && txByte.data == SDR_CODE_IO_FAIL;
  endproperty
  a_io_fail: assert property (p_io_fail)
    else $error("io failure not reported");
endmodule : sdr_reporter

/* hdl/sdr_slot_encode.sv */
// module: slot number to module/slot byte encoder
`timescale 1ns/1ns
module sdr_slot_encode
  import sdr_pkg::*;
(
  input  wire logic [5:0] slotIn,
  output logic      [7:0] slotByte
);
  // ----------------------------------------------------------------
  // encoder
  // ----------------------------------------------------------------
  // out of range numbers are reported as unknown rather than aliased
  always_comb begin
    if (slotIn == 6'h00 || slotIn > SDR_SLOT_MAX) begin
      slotByte = SDR_SLOT_NONE;
    end else begin
      slotByte = {2'b00, slotIn};
    end
  end
endmodule : sdr_slot_encode

/* tb/sdr_master_model.sv */
// model: far-side consumer of the reporter's diagnostic bytes
`timescale 1ns/1ns
module sdr_master_model (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic slowMode,
  output logic      txReady
);
  // ----------------------------------------------------------------
  // accept strobe
  // ----------------------------------------------------------------
  // prompt mode takes every byte, slow mode stalls at random
  always @(posedge sys_clk) begin
    if (!rst_n)
      txReady <= 1'b0;
    else
      txReady <= !slowMode || ($urandom_range(3, 0) == 0);
  end
endmodule : sdr_master_model

/* tb/slave_diagnostic_reporter_tb.sv */
// testbench: event messages, restart and ready code of the reporter
`timescale 1ns/1ns
module slave_diagnostic_reporter_tb;
  import sdr_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        sys_clk = 1'b0, rst_n = 1'b0, setAddrReq = 1'b0;
  logic [6:0]  setAddrValue = 7'h00, newAddr;
  logic        slaveReady = 1'b0, dataExchange = 1'b0, ackDelay = 1'b0;
  logic        ioReadFail = 1'b0, ioWriteFail = 1'b0, slowMode = 1'b0;
  logic [5:0]  ioSlot = 6'h00, ackSlot = 6'h00, slot;
  logic        txReady, txValid, restartReq, busy;
  sdr_byte_s   txByte;
  logic [6:0]  stationAddress;
  logic [7:0]  readyCode, slotExp;
  logic [9:0]  expQ[$];
  int          error_cnt = 0, checks_done = 0, cyc = 0, n;
  int          slotTab[5] = '{5, 0, 40, 32, 1};

  always #10 sys_clk = ~sys_clk;

  sdr_reporter dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .setAddrReq(setAddrReq), .setAddrValue(setAddrValue),
    .slaveReady(slaveReady), .dataExchange(dataExchange),
    .ioReadFail(ioReadFail), .ioWriteFail(ioWriteFail), .ioSlot(ioSlot),
    .ackDelay(ackDelay), .ackSlot(ackSlot), .txReady(txReady),
    .txValid(txValid), .txByte(txByte), .restartReq(restartReq),
    .stationAddress(stationAddress), .readyCode(readyCode), .busy(busy));
  sdr_master_model master (.sys_clk(sys_clk), .rst_n(rst_n),
    .slowMode(slowMode), .txReady(txReady));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(string what, logic [9:0] seen, logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // a wait that runs out is a mismatch and ends the run at once
  task automatic lim_chk(int cnt, int lim);
    if (cnt >= lim) begin
      error_cnt++;
      $display("unexpected wait: limit %0d reached", lim);
      end_sim();
    end
  endtask : lim_chk

  // wait until the engine takes the held event, then drop every source but dataExchange
  task automatic wait_take();
    n = 0;
    while (busy !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    lim_chk(n, 50);
    setAddrReq  <= 1'b0;
    ioReadFail  <= 1'b0;
    ioWriteFail <= 1'b0;
    ackDelay    <= 1'b0;
  endtask : wait_take

  task automatic wait_idle();
    n = 0;
    while ((busy !== 1'b0 || expQ.size() != 0) && n < 500) begin
      @(posedge sys_clk);
      n++;
    end
    lim_chk(n, 500);
  endtask : wait_idle

  // ----------------------------------------------------------------
  // monitor: every accepted byte must match the oldest note
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst_n && txValid === 1'b1 && txReady === 1'b1) begin
      if (expQ.size() == 0)
        chk("spare byte", txByte, 10'h3FF);
      else
        chk("tx byte", txByte, expQ.pop_front());
    end
    cyc++;
    // whole run needs well under this many cycles
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(61));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk("reset addr", {3'h0, stationAddress}, {3'h0, SDR_ADDR_RESET});
    chk("ready idle", {2'h0, readyCode}, 10'h000);
    // ready status shows only on the internal code, never on the link
    slaveReady <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("ready code", {2'h0, readyCode}, {2'h0, 8'h3D});
    slotTab[4] = $urandom_range(32, 1);
    // io failures and delayed ack, boundary and out-of-range slots
    for (int k = 0; k < 5; k++) begin
      slot = 6'(slotTab[k]);
      slotExp = (slot == 6'h00 || slot > 6'h20) ? 8'h00 : {2'h0, slot};
      expQ.push_back({8'h2B, 1'b1, 1'b0});
      expQ.push_back({slotExp, 1'b0, 1'b1});
      slowMode <= k[0];
      ioSlot   <= slot;
      ackSlot  <= slot;
      if (k % 3 == 0)
        ioReadFail <= 1'b1;
      else if (k % 3 == 1)
        ioWriteFail <= 1'b1;
      else
        ackDelay <= 1'b1;
      @(posedge sys_clk);
      wait_take();
      wait_idle();
    end
    // data exchange entry: single byte message
    expQ.push_back({8'h3E, 1'b1, 1'b1});
    dataExchange <= 1'b1;
    @(posedge sys_clk);
    wait_take();
    wait_idle();
    // address change: message first, then restart, then new address
    newAddr = 7'($urandom_range(125, 1));
    expQ.push_back({8'h3C, 1'b1, 1'b1});
    slowMode     <= 1'b1;
    setAddrValue <= newAddr;
    setAddrReq   <= 1'b1;
    @(posedge sys_clk);
    wait_take();
    n = 0;
    while (restartReq !== 1'b1 && n < 500) begin
      @(posedge sys_clk);
      n++;
    end
    lim_chk(n, 500);
    chk("msg before restart", 10'(expQ.size()), 10'h000);
    chk("addr in restart", {3'h0, stationAddress},
        {3'h0, SDR_ADDR_RESET});
    n = 0;
    while (restartReq === 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    lim_chk(n, 100);
    chk("restart length", 10'(n >= 8 && n <= 20), 10'h001);
    repeat (2) @(posedge sys_clk);
    chk("new addr", {3'h0, stationAddress}, {3'h0, newAddr});
    dataExchange <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk("queue left", 10'(expQ.size()), 10'h000);
    end_sim();
  end
endmodule : slave_diagnostic_reporter_tb
